// ==== sfw_watchdog.sv ====
// Software fault watchdog: prescaled 7-bit downcounter with an AHB-Lite register slave.
// Assumes the system resets this block through hresetn, and that halt_req pulses
// for one cycle when the CPU executes a halt instruction.
//
// Implementation choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
module sfw_watchdog
	import sfw_pkg::*;
#(
	parameter int PRESCALE = SFW_PRESCALE,
	parameter int RST_CYCLES = SFW_RST_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic halt_req,
	output logic halt_grant,
	output logic device_reset_n
);
	initial begin
		if (PRESCALE < 2) $error("PRESCALE must be at least two");
	end

	// ****************************************
	// AHB-Lite address phase capture
	// ****************************************
	sfw_req_t req_q;
	logic [31:0] hrdata_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_q <= '0;
		end else if (hready) begin
			req_q.sel <= hsel && htrans[1];
			req_q.write <= hwrite;
			req_q.addr <= haddr[7:0];
		end
	end

	// Zero wait states; every access answers OKAY, unmapped reads return zero
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	logic wr_ctrl;
	logic wr_opt;
	assign wr_ctrl = req_q.sel && req_q.write && (req_q.addr == SFW_CTRL_OFFSET);
	assign wr_opt = req_q.sel && req_q.write && (req_q.addr == SFW_OPT_OFFSET);

	// ****************************************
	// Prescaler
	// ****************************************
	logic [$clog2(PRESCALE)-1:0] pre_q;
	logic tick;
	assign tick = (pre_q == ($clog2(PRESCALE))'(PRESCALE - 1));

	// Free running; never touched by register writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_q <= '0;
		end else if (tick) begin
			pre_q <= '0;
		end else begin
			pre_q <= pre_q + 1'b1;
		end
	end

	// ****************************************
	// Options and activation
	// ****************************************
	logic hw_mode_q;
	logic halt_noreset_q;
	logic act_q;
	logic active;

	// Option bits model the option byte: writable until the first write locks them
	logic opt_lock_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hw_mode_q <= SFW_OPT_RESET[SFW_OPT_HW_BIT];
			halt_noreset_q <= SFW_OPT_RESET[SFW_OPT_HALT_BIT];
			opt_lock_q <= 1'b0;
		end else if (wr_opt && !opt_lock_q) begin
			hw_mode_q <= hwdata[SFW_OPT_HW_BIT];
			halt_noreset_q <= hwdata[SFW_OPT_HALT_BIT];
			opt_lock_q <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			act_q <= SFW_CTRL_RESET[SFW_ACT_BIT];
		end else if (wr_ctrl && hwdata[SFW_ACT_BIT]) begin
			act_q <= 1'b1;
		end
	end

	assign active = act_q || hw_mode_q;

	// ****************************************
	// Downcounter
	// ****************************************
	logic [6:0] count_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_q <= SFW_CTRL_RESET[6:0];
		end else if (wr_ctrl) begin
			count_q <= hwdata[6:0];
		end else if (tick) begin
			count_q <= count_q - 1'b1;
		end
	end

	// ****************************************
	// Reset triggers
	// ****************************************
	logic roll;
	logic soft_rst;
	logic halt_rst;
	logic fire;
	assign roll = tick && !wr_ctrl && (count_q == SFW_COUNT_ROLL);
	// New activation counts as well, so a write of 10xxxxxx fires even while inactive
	assign soft_rst = wr_ctrl && !hwdata[SFW_MSB_BIT] && (hwdata[SFW_ACT_BIT] || active);
	assign halt_rst = halt_req && active && !halt_noreset_q;
	assign fire = (roll && active) || soft_rst || halt_rst;

	// Halt proceeds only when it will not reset the device
	assign halt_grant = halt_req && !halt_rst;

	logic pulse_active;
	sfw_pulse_gen #(
		.CYCLES(RST_CYCLES)
	) u_pulse (
		.hclk(hclk),
		.hresetn(hresetn),
		.trigger(fire),
		.active(pulse_active)
	);

	assign device_reset_n = !pulse_active;

	// ****************************************
	// Read data
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= '0;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			unique case (haddr[7:0])
				SFW_CTRL_OFFSET: hrdata_q <= {24'h000000, act_q, count_q};
				SFW_OPT_OFFSET: hrdata_q <= {29'h00000000, opt_lock_q, halt_noreset_q, hw_mode_q};
				SFW_STAT_OFFSET: hrdata_q <= {30'h00000000, pulse_active, active};
				default: hrdata_q <= 32'h00000000;
			endcase
		end
	end
endmodule // sfw_watchdog

// ==== sfw_pkg.sv ====
// Package for the software fault watchdog: register map, field layout, timing constants.
// Assumes a 250 MHz system clock and three AHB-Lite slave register words.
package sfw_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] SFW_CTRL_OFFSET = 8'h00;
	localparam logic [7:0] SFW_OPT_OFFSET = 8'h04;
	localparam logic [7:0] SFW_STAT_OFFSET = 8'h08;

	// ****************************************
	// Fields and reset values
	// ****************************************
	localparam int SFW_ACT_BIT = 7;
	localparam int SFW_MSB_BIT = 6;
	localparam logic [7:0] SFW_CTRL_RESET = 8'h7f;
	localparam logic [6:0] SFW_COUNT_ROLL = 7'h40;
	localparam int SFW_OPT_HW_BIT = 0;
	localparam int SFW_OPT_HALT_BIT = 1;
	localparam logic [1:0] SFW_OPT_RESET = 2'h0;

	// ****************************************
	// Timing
	// ****************************************
	localparam int SFW_PRESCALE = 16000;
	localparam int SFW_CLK_MHZ = 250;
	localparam int SFW_RST_PULSE_NS = 30000;
	localparam int SFW_RST_CYCLES = (SFW_RST_PULSE_NS * SFW_CLK_MHZ) / 1000;

	// ****************************************
	// Bus carrier
	// ****************************************
	typedef struct packed {
		logic sel;
		logic write;
		logic [7:0] addr;
	} sfw_req_t;

endpackage

// ==== sfw_pulse_gen.sv ====
// Reset pulse stretcher: holds an output for a fixed number of cycles after a trigger.
// Assumes a one-cycle trigger in the hclk domain.
`timescale 1ns/1ps
module sfw_pulse_gen #(
	parameter int CYCLES = 7500
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic trigger,
	output logic active
);
	initial begin
		if (CYCLES < 1) $error("CYCLES must be at least one");
	end

	logic [$clog2(CYCLES+1)-1:0] cnt_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= '0;
		end else if (trigger) begin
			cnt_q <= ($clog2(CYCLES+1))'(CYCLES);
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			active <= 1'b0;
		end else begin
			active <= trigger || (cnt_q > 1);
		end
	end
endmodule // sfw_pulse_gen

// ==== sfw_chk.sv ====
// Port assertions for the software fault watchdog.
// Assumes a bind to sfw_watchdog, which hands on its RST_CYCLES.
`timescale 1ns/1ps
module sfw_chk #(
	parameter int RST_CYCLES = 4
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic halt_req,
	input wire logic halt_grant,
	input wire logic device_reset_n
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	logic ap;
	logic wr_q;
	int low_q;
	assign ap = hsel && hready && htrans[1];
	// ****
	// Helpers: write data phase, reset pulse length
	// ****
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			low_q <= 0;
		end else begin
			wr_q <= ap && hwrite && haddr[7:0] == 8'h00;
			low_q <= device_reset_n ? 0 : low_q + 1;
		end
	end
	property p_ready;
		hreadyout;
	endproperty
	a_ready: assert property (p_ready) else $error("hreadyout low");
	property p_okay;
		!hresp;
	endproperty
	a_okay: assert property (p_okay) else $error("hresp not okay");
	property p_grant;
		halt_grant |-> halt_req;
	endproperty
	a_grant: assert property (p_grant) else $error("grant without halt");
	property p_halt_fire;
		halt_req && !halt_grant |=> !device_reset_n;
	endproperty
	a_halt_fire: assert property (p_halt_fire) else $error("refused halt gave no reset");
	property p_sw_rst;
		wr_q && hwdata[7:6] == 2'h2 |=> !device_reset_n;
	endproperty
	a_sw_rst: assert property (p_sw_rst) else $error("software reset missing");
	property p_len;
		$rose(device_reset_n) |-> low_q == RST_CYCLES;
	endproperty
	a_len: assert property (p_len) else $error("reset pulse length");
	property p_len_max;
		low_q <= RST_CYCLES;
	endproperty
	a_len_max: assert property (p_len_max) else $error("reset pulse too long");
	property p_rd_hold;
		!(ap && !hwrite) |=> $stable(hrdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("hrdata moved without read");
endmodule // sfw_chk

bind sfw_watchdog sfw_chk #(.RST_CYCLES(RST_CYCLES)) i_chk (.*);

// ==== sfw_watchdog_tb_top.sv ====
// Self-checking bench for sfw_watchdog over AHB-Lite.
// Assumes short PRESCALE and RST_CYCLES so timeouts fit the run.
`timescale 1ns/1ps
module sfw_watchdog_tb_top import sfw_pkg::*;;
	localparam int PS = 16;
	localparam int RC = 4;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic halt_req = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, a, b;
	logic hready, hreadyout, hresp, halt_grant, device_reset_n;
	int n_mismatch = 0;
	int comparisons = 0;
	assign hready = hreadyout;
	sfw_watchdog #(.PRESCALE(PS), .RST_CYCLES(RC)) i_dut (.*);
	initial forever #2 hclk = ~hclk;
	// ****
	// Tasks
	// ****
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic bus(logic w, logic [7:0] ad, logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, ad};
		@(posedge hclk);
		while (!hready) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (!hready) @(posedge hclk);
		r = hrdata;
	endtask
	task automatic wr(logic [7:0] ad, logic [7:0] d);
		bus(1'b1, ad, {24'h0, d}, a);
	endtask
	task automatic rd(logic [7:0] ad, logic [31:0] e, logic [31:0] m);
		bus(1'b0, ad, 32'h0, b);
		chk("hrdata", e & m, b & m);
	endtask
	task automatic rst();
		hresetn <= 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
	endtask
	// Waits a bounded time for the reset output, then lets the pulse end
	// Samples 1 ns after each edge so a pulse launched by that edge is seen settled
	task automatic wlow(int lo, int hi);
		int n = 0;
		#1;
		while (device_reset_n === 1'b1 && n < hi) begin
			@(posedge hclk);
			#1;
			n++;
		end
		chk("reset delay", 1, n >= lo && n < hi);
		repeat (RC + 2) @(posedge hclk);
	endtask
	task automatic halt(logic g);
		halt_req <= 1'b1;
		@(posedge hclk);
		chk("halt_grant", {31'h0, g}, {31'h0, halt_grant});
		halt_req <= 1'b0;
		repeat (RC + 2) @(posedge hclk);
	endtask
	task automatic finish_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#12000;
		n_mismatch++;
		finish_test();
	end
	initial begin
		rst();
		rd(SFW_CTRL_OFFSET, 32'h7f, 32'hff);
		bus(1'b0, SFW_CTRL_OFFSET, 32'h0, a);
		repeat (4 * PS - 2) @(posedge hclk);
		bus(1'b0, SFW_CTRL_OFFSET, 32'h0, b);
		chk("count", a - 4, b);
		halt(1'b1);
		wr(SFW_CTRL_OFFSET, 8'hc1);
		wlow(PS, 2 * PS + 8);
		wr(SFW_CTRL_OFFSET, 8'h7f);
		rd(SFW_CTRL_OFFSET, 32'h80, 32'h80);
		halt(1'b0);
		rst();
		rd(SFW_STAT_OFFSET, 32'h0, 32'h1);
		wr(SFW_OPT_OFFSET, 8'h02);
		wr(SFW_CTRL_OFFSET, 8'h80);
		wlow(0, 1);
		wr(SFW_CTRL_OFFSET, 8'hff);
		halt(1'b1);
		rst();
		wr(SFW_OPT_OFFSET, 8'h01);
		rd(SFW_STAT_OFFSET, 32'h1, 32'h1);
		wlow(64 * PS - 24, 64 * PS + 16);
		finish_test();
	end
endmodule // sfw_watchdog_tb_top
